// file: rc_alu.sv
// Eight-bit arithmetic and logic unit.
`timescale 1ns/1ps
module rc_alu (
   input  rc_pkg::rc_op_t  op,
   input  wire logic [7:0] a,
   input  wire logic [7:0] w,
   input  wire logic       c_in,
   input  wire logic [2:0] bitn,
   output rc_pkg::rc_alu_t y
);
   import rc_pkg::*;
   function automatic rc_alu_t add8(input logic [7:0] x, input logic [7:0] v, input logic ci);
      logic [8:0] s;
      logic [4:0] n;
      s = {1'b0, x} + {1'b0, v} + {8'h00, ci};
      n = {1'b0, x[3:0]} + {1'b0, v[3:0]} + {4'h0, ci};
      add8 = '{res: s[7:0], c: s[8], dcarry: n[4]};
   endfunction : add8
   always_comb begin
      y = '{res: a, c: c_in, dcarry: 1'b0};
      case (op)
         add_acc_to_file, add_literal: y = add8(a, w, 1'b0);
         sub_acc_from_file, sub_acc_from_literal: y = add8(a, ~w, 1'b1);
         and_acc_with_file, and_literal: y.res = a & w;
         or_acc_with_file, or_literal: y.res = a | w;
         xor_acc_with_file, xor_literal: y.res = a ^ w;
         complement_file_reg: y.res = ~a;
         swap_nibbles: y.res = {a[3:0], a[7:4]};
         increment_file_reg, increment_skip_zero: y.res = a + 8'h01;
         decrement_file_reg, decrement_skip_zero: y.res = a - 8'h01;
         rotate_left_carry: y = '{res: {a[6:0], c_in}, c: a[7], dcarry: 1'b0};
         rotate_right_carry: y = '{res: {c_in, a[7:1]}, c: a[0], dcarry: 1'b0};
         clear_file_reg, clear_accumulator: y.res = 8'h00;
         store_acc_to_file: y.res = w;
         bit_clear: y.res = a & ~(8'h01 << bitn);
         bit_set: y.res = a | (8'h01 << bitn);
         default: ;
      endcase
   end
endmodule : rc_alu

// file: rc_core.sv
// Instruction decode and execute core with four-phase cycle.
`timescale 1ns/1ps
`include "rc_map.svh"
module rc_core #(
   parameter logic [6:0] TIMER_ADDR = `RC_TMR_ADDR,
   parameter logic [6:0] PORT_BASE  = `RC_PORT_BASE,
   parameter int         PORTS      = `RC_PORTS
) (
   input  wire logic [0:0]         mclk,
   input  wire logic               rst,
   input  wire logic [`RC_IW-1:0]  instr,
   input  wire logic [7:0]         file_rd_data,
   input  wire logic [8*PORTS-1:0] pin_levels,
   input  wire logic               presc_on_timer,
   output rc_pkg::rc_file_t        file_bus,
   output rc_pkg::rc_pgm_t         pgm_req,
   output rc_pkg::rc_status_t      status,
   output logic [7:0]              acc,
   output logic                    cyc_start,
   output logic                    discard,
   output logic                    presc_clr,
   output logic                    wdt_clr,
   output logic                    standby
);
   import rc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // State.

   typedef struct packed {
      logic [1:0]         q;
      logic [`RC_IW-1:0]  ir;
      logic               flush;
      logic [7:0]         w;
      rc_status_t         stat;
      logic [7:0]         opnd;
      rc_file_t           file;
      rc_pgm_t            pgm;
      logic               ps_clr;
      logic               wdt_clr;
      logic               standby;
      logic               cyc_start;
      logic [8*PORTS-1:0] pins1;
      logic [8*PORTS-1:0] pins2;
   } rc_core_st_t;

   rc_core_st_t st;
   rc_core_st_t next_st;
   rc_dec_t     dec;
   rc_alu_t     alu;
   logic [7:0]  opa;
   logic        exec;
   logic        skip_hit;
   logic        port_hit;
   logic [7:0]  pin_byte;

   function automatic logic is_port(input logic [6:0] a);
      is_port = (a >= PORT_BASE) && (a < PORT_BASE + 7'(PORTS));
   endfunction : is_port

   function automatic logic [7:0] port_byte(input logic [8*PORTS-1:0] p, input logic [6:0] a);
      port_byte = 8'h00;
      for (int i = 0; i < PORTS; i++) begin
         if (a == PORT_BASE + 7'(i)) port_byte = p[i*8 +: 8];
      end
   endfunction : port_byte

   ////////////////////////////////////////////////////////////////////////////
   // Decode and arithmetic.

   rc_decode u_decode (
      .instr (st.ir),
      .dec   (dec)
   );

   assign opa = dec.use_lit ? dec.lit : st.opnd;

   rc_alu u_alu (
      .op   (dec.op),
      .a    (opa),
      .w    (st.w),
      .c_in (st.stat.c),
      .bitn (dec.bitn),
      .y    (alu)
   );

   // The last phase commits unless this cycle is a discarded one.
   assign exec = (st.q == `RC_Q_LAST) && !st.flush;
   assign port_hit = is_port(dec.faddr);
   assign pin_byte = port_byte(st.pins2, dec.faddr);

   always_comb begin
      case (dec.op)
         decrement_skip_zero, increment_skip_zero: skip_hit = (alu.res == 8'h00);
         bit_test_skip_clear: skip_hit = !st.opnd[dec.bitn];
         bit_test_skip_set: skip_hit = st.opnd[dec.bitn];
         default: skip_hit = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer.

   always_comb begin
      next_st = st;
      next_st.pins1 = pin_levels;
      next_st.pins2 = st.pins1;
      next_st.file.we = 1'b0;
      next_st.pgm.valid = 1'b0;
      next_st.ps_clr = 1'b0;
      next_st.wdt_clr = 1'b0;
      next_st.standby = 1'b0;
      next_st.q = st.q + 2'h1;
      next_st.cyc_start = (st.q == `RC_Q_LAST);
      case (st.q)
         2'h0: next_st.file.addr = dec.faddr;
         `RC_Q_READ: next_st.opnd = port_hit ? pin_byte : file_rd_data;
         `RC_Q_LAST: begin
            next_st.ir = instr;
            next_st.flush = 1'b0;
            next_st.pgm.valid = 1'b1;
            next_st.pgm.op = pgm_step;
            next_st.pgm.target = dec.target;
            if (!st.flush) begin
               if (dec.to_acc) next_st.w = alu.res;
               if (dec.to_file) begin
                  next_st.file.we = 1'b1;
                  next_st.file.wdata = alu.res;
               end
               if (dec.flg[2]) next_st.stat.c = alu.c;
               if (dec.flg[1]) next_st.stat.digit_carry_flag = alu.dcarry;
               if (dec.flg[0]) next_st.stat.z = (alu.res == 8'h00);
               case (dec.op)
                  watchdog_clear: begin
                     next_st.stat.timeout_flag = 1'b1;
                     next_st.stat.powerdown_flag = 1'b1;
                     next_st.wdt_clr = 1'b1;
                  end
                  enter_standby: begin
                     next_st.stat.timeout_flag = 1'b1;
                     next_st.stat.powerdown_flag = 1'b0;
                     next_st.standby = 1'b1;
                  end
                  call_sub: next_st.pgm.op = pgm_call;
                  jump_absolute: next_st.pgm.op = pgm_jump;
                  return_sub, return_with_literal: next_st.pgm.op = pgm_ret;
                  interrupt_return: next_st.pgm.op = pgm_reti;
                  default: ;
               endcase
               next_st.flush = dec.two_cyc || skip_hit;
               if (dec.to_file && dec.faddr == TIMER_ADDR && presc_on_timer) begin
                  next_st.ps_clr = 1'b1;
               end
            end
         end
         default: ;
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st <= '0;
         st.w <= `RC_W_RST;
         st.stat <= `RC_STAT_RST;
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs.

   assign file_bus = st.file;
   assign pgm_req = st.pgm;
   assign status = st.stat;
   assign acc = st.w;
   assign cyc_start = st.cyc_start;
   assign discard = st.flush;
   assign presc_clr = st.ps_clr;
   assign wdt_clr = st.wdt_clr;
   assign standby = st.standby;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions.

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   cycle_len_a: assert property (
      cyc_start |=> !cyc_start [*3] ##1 cyc_start)
      else $error("instruction cycle is not four clocks");

   store_acc_a: assert property (
      exec && dec.op == store_acc_to_file |=> file_bus.we && file_bus.wdata == $past(st.w))
      else $error("store of W to file missing");

   dest_acc_a: assert property (
      exec && dec.to_acc |=> !file_bus.we && acc == $past(alu.res))
      else $error("result not placed in W");

   clear_acc_a: assert property (
      exec && dec.op == clear_accumulator |=> acc == 8'h00 && status.z)
      else $error("W clear did not clear or set zero");

   skip_zero_a: assert property (
      exec && dec.op inside {decrement_skip_zero, increment_skip_zero} && alu.res == 8'h00
      |=> discard [*4] ##1 !discard)
      else $error("zero result did not discard exactly one cycle");

   bit_skip_a: assert property (
      exec && dec.op == bit_test_skip_set && !st.opnd[dec.bitn] |=> !discard)
      else $error("bit test skipped on clear bit");

   flushed_quiet_a: assert property (
      st.q == `RC_Q_LAST && st.flush
      |=> !file_bus.we && acc == $past(acc) && pgm_req.op == pgm_step)
      else $error("discarded cycle had an effect");

   jump_req_a: assert property (
      exec && dec.op == jump_absolute
      |=> pgm_req.valid && pgm_req.op == pgm_jump && pgm_req.target == $past(dec.target) && discard)
      else $error("jump request wrong");

   wdt_flags_a: assert property (
      exec && dec.op == enter_standby
      |=> status.timeout_flag && !status.powerdown_flag && standby ##1 !standby)
      else $error("standby flags wrong");

   swap_flags_a: assert property (
      exec && dec.op == swap_nibbles |=> status == $past(status))
      else $error("swap changed a flag");

   presc_clr_a: assert property (
      presc_clr |-> $past(exec && dec.to_file && dec.faddr == TIMER_ADDR && presc_on_timer))
      else $error("prescaler cleared without a timer write");

   pin_read_a: assert property (
      st.q == `RC_Q_READ && port_hit |=> st.opnd == $past(pin_byte))
      else $error("port read did not use pins");

   unknown_op_a: assert property (
      exec && dec.op == no_operation
      |=> acc == $past(acc) && !file_bus.we && status == $past(status) && !discard)
      else $error("no-operation changed state");

   lit_and_a: assert property (
      exec && dec.op == and_literal |=> acc == ($past(st.w) & $past(dec.lit)))
      else $error("literal AND wrong");

   clr_skip_a: assert property (
      exec && dec.op == bit_test_skip_clear && !st.opnd[dec.bitn] |=> discard)
      else $error("bit test did not skip on clear bit");

   or_flags_a: assert property (
      exec && dec.op == or_acc_with_file |=> status == $past(status))
      else $error("file OR changed a flag");

   rot_flags_a: assert property (
      exec && dec.op == rotate_left_carry |=> status.c == $past(st.opnd[7]) && status.z == $past(status.z))
      else $error("rotate left carry wrong");

   call_req_a: assert property (
      exec && dec.op == call_sub |=> pgm_req.valid && pgm_req.op == pgm_call && discard)
      else $error("call request wrong");

   ret_lit_a: assert property (
      exec && dec.op == return_with_literal |=> acc == $past(dec.lit) && pgm_req.op == pgm_ret && discard)
      else $error("literal return wrong");

   wdt_clr_a: assert property (
      exec && dec.op == watchdog_clear |=> wdt_clr && status.timeout_flag && status.powerdown_flag)
      else $error("watchdog clear flags wrong");

endmodule : rc_core

// file: rc_core_bench.sv
// Self-checking bench for the instruction core.
`timescale 1ns/1ps
module rc_core_bench;
   import rc_pkg::*;
   localparam int N = 300;
   localparam logic [13:0] DIR [12] = '{14'h0081, 14'h0a85, 14'h0103, 14'h0064, 14'h0063, 14'h0008,
      14'h0009, 14'h0190, 14'h0f90, 14'h0b90, 14'h3e05, 14'h0000};
   logic        mclk, rst, presc_on_timer, skip, armed;
   logic [13:0] instr;
   logic [7:0]  file_rd_data, acc, w, fm [128];
   logic [39:0] pin_levels;
   logic [46:0] obs, want, q [$];
   rc_file_t    file_bus;
   rc_pgm_t     pgm_req;
   rc_status_t  status, st;
   logic        cyc_start, presc_clr, wdt_clr, standby, discard;
   logic [N-1:0] presc_plan;
   int          n_errors = 0, total_checks = 0, seed = 73, gap = 0;
   rc_core u_dut (.mclk(mclk), .rst(rst), .instr(instr), .file_rd_data(file_rd_data),
      .pin_levels(pin_levels), .presc_on_timer(presc_on_timer), .file_bus(file_bus),
      .pgm_req(pgm_req), .status(status), .acc(acc), .cyc_start(cyc_start), .discard(discard),
      .presc_clr(presc_clr), .wdt_clr(wdt_clr), .standby(standby));
   rc_prog_mem u_mem (.mclk(mclk), .cyc_start(cyc_start), .file_bus(file_bus), .instr(instr),
      .file_rd_data(file_rd_data));
   ////////////////////////////////////////////////////////////////////////////
   // add and subtract
   task automatic arith(input logic [7:0] a, input logic [7:0] b, input logic ci, output logic [7:0] r);
      logic [4:0] h;
      h = a[3:0] + b[3:0] + ci;
      {st.c, r} = a + b + ci;
      st.digit_carry_flag = h[4];
      st.z = r == 8'h0;
   endtask : arith
   task automatic exec(input logic [13:0] iw);
      logic [7:0]  a, r;
      logic [2:0]  op, sd;
      logic [10:0] t;
      logic        wr;
      a = (iw[6:0] >= 7'h05 && iw[6:0] <= 7'h09) ? pin_levels[8*(iw[6:0]-7'h05) +: 8] : fm[iw[6:0]];
      r = a;
      op = pgm_step;
      sd = 3'h0;
      t = 11'h0;
      wr = 0;
      if (skip)
         skip = 0;
      else if (iw[13:8] == 6'h00) begin
         wr = iw[7];
         r = w;
         case (iw[7:0])
            8'h08: op = pgm_ret;
            8'h09: op = pgm_reti;
            8'h64: sd = 3'h2;
            8'h63: sd = 3'h1;
            default: ;
         endcase
      end else if (iw[13:8] == 6'h01) begin
         r = 8'h0;
         wr = iw[7];
         if (iw[7] || iw[7:0] == 8'h03)
            st.z = 1;
         if (iw[7:0] == 8'h03)
            w = 8'h0;
      end else if (iw[13:12] == 2'h0) begin
         case (iw[11:8])
            4'h2: arith(a, ~w, 1, r);
            4'h7: arith(a, w, 0, r);
            4'h3, 4'hb: r = a - 8'h1;
            4'ha, 4'hf: r = a + 8'h1;
            4'h4: r = a | w;
            4'h5: r = a & w;
            4'h6: r = a ^ w;
            4'h9: r = ~a;
            4'hc: {r, st.c} = {st.c, a};
            4'hd: {st.c, r} = {a, st.c};
            4'he: r = {a[3:0], a[7:4]};
            default: ;
         endcase
         if (iw[11:8] inside {4'h3, 4'h5, 4'h6, 4'h8, 4'h9, 4'ha})
            st.z = r == 8'h0;
         skip = iw[11:8] inside {4'hb, 4'hf} && r == 8'h0;
         wr = iw[7];
         if (!iw[7])
            w = r;
      end else if (iw[13:12] == 2'h1) begin
         r[iw[9:7]] = iw[11:10] == 2'h1;
         wr = !iw[11];
         skip = iw[11] && a[iw[9:7]] == iw[10];
      end else if (iw[13:12] == 2'h2) begin
         op = iw[11] ? pgm_jump : pgm_call;
         t = iw[10:0];
      end else begin
         r = iw[7:0];
         case (iw[11:8])
            4'h8: r = r | w;
            4'h9: r = r & w;
            4'ha: r = r ^ w;
            4'hc, 4'hd: arith(r, ~w, 1, r);
            4'he, 4'hf: arith(r, w, 0, r);
            default: ;
         endcase
         if (iw[11:10] == 2'h2 && iw[9:8] != 2'h3)
            st.z = r == 8'h0;
         if (iw[11:8] != 4'hb)
            w = r;
         if (iw[11:10] == 2'h1)
            op = pgm_ret;
      end
      if (op != pgm_step)
         skip = 1;
      if (sd != 3'h0)
         {st.timeout_flag, st.powerdown_flag} = {1'b1, sd[1]};
      if (wr)
         fm[iw[6:0]] = r;
      sd[2] = wr && iw[6:0] == 7'h01 && presc_on_timer;
      q.push_back({w, st, wr, wr ? {iw[6:0], r} : 15'h0, op, t, sd, skip});
   endtask : exec
   task automatic report_and_stop();
      if (n_errors == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : report_and_stop
   ////////////////////////////////////////////////////////////////////////////
   always @(posedge mclk) begin
      gap++;
      if (rst)
         armed = 0;
      else begin
         obs = {acc, status, file_bus.we, file_bus.we ? {file_bus.addr, file_bus.wdata} : 15'h0,
            pgm_req.op, pgm_req.op inside {pgm_call, pgm_jump} ? pgm_req.target : 11'h0,
            presc_clr, wdt_clr, standby, discard};
         if (armed && pgm_req.valid === 1'b1 && q.size() > 0) begin
            want = q.pop_front();
            total_checks += 2;
            if (obs !== want) begin
               n_errors++;
               $display("wrong value result expected %h seen %h", want, obs);
            end
            if (gap !== 4) begin // four clocks each
               n_errors++;
               $display("wrong value spacing expected 4 seen %0d", gap);
            end
         end
         if (cyc_start === 1'b1) begin
            armed = 1;
            gap = 0;
         end
      end
   end
   initial begin
      mclk = 0;
      forever #2.5 mclk = ~mclk;
   end
   initial begin
      @(negedge rst);
      for (int k = 0; k < N; k++) begin
         do @(posedge mclk); while (cyc_start !== 1'b1);
         #1 presc_on_timer = presc_plan[k];
      end
   end
   initial begin
      #(5 * (4 * N + 400));
      n_errors++;
      report_and_stop();
   end
   initial begin
      rst = 1;
      pin_levels[39:8] = $random(seed);
      pin_levels[7:0] = 8'($random(seed));
      w = 8'h0;
      st = 5'h18;
      skip = 0;
      for (int i = 0; i < 128; i++) begin
         fm[i] = 8'($random(seed));
         u_mem.ram[i] = fm[i];
      end
      for (int i = 0; i < 512; i++) begin
         u_mem.prog[i] = i < 12 ? DIR[i] : 14'($random(seed));
         if (i < N) begin
            presc_plan[i] = 1'($random(seed));
            presc_on_timer = presc_plan[i];
            exec(u_mem.prog[i]);
         end
      end
      repeat (6) @(posedge mclk);
      #1 rst = 0;
      for (int i = 0; i < 4 * N + 100 && q.size() > 0; i++)
         @(posedge mclk);
      if (q.size() > 0)
         n_errors++;
      report_and_stop();
   end
endmodule : rc_core_bench

// file: rc_decode.sv
// Instruction word decoder.
`timescale 1ns/1ps
`include "rc_map.svh"
module rc_decode (
   input  wire logic [`RC_IW-1:0] instr,
   output rc_pkg::rc_dec_t        dec
);
   import rc_pkg::*;
   logic       dst;
   logic [7:0] lo;
   always_comb begin
      dec = '0;
      dec.faddr = instr[`RC_FADDR_HI:0];
      dec.bitn = instr[`RC_BIT_HI:`RC_BIT_LO];
      dec.lit = instr[`RC_LIT_HI:0];
      dec.target = instr[`RC_TGT_HI:0];
      dst = instr[`RC_DEST_BIT];
      lo = instr[7:0];
      case (instr[13:12])
         `RC_CLS_BYTE: begin
            dec.to_file = dst;
            dec.to_acc = !dst;
            case (instr[11:8])
               `RC_BY_ADD:   dec.op = add_acc_to_file;
               `RC_BY_SUB:   dec.op = sub_acc_from_file;
               `RC_BY_AND:   dec.op = and_acc_with_file;
               `RC_BY_IOR:   dec.op = or_acc_with_file;
               `RC_BY_XOR:   dec.op = xor_acc_with_file;
               `RC_BY_COM:   dec.op = complement_file_reg;
               `RC_BY_MOV:   dec.op = move_file_reg;
               `RC_BY_SWAP:  dec.op = swap_nibbles;
               `RC_BY_INC:   dec.op = increment_file_reg;
               `RC_BY_DEC:   dec.op = decrement_file_reg;
               `RC_BY_DECSZ: dec.op = decrement_skip_zero;
               `RC_BY_INCSZ: dec.op = increment_skip_zero;
               `RC_BY_RL:    dec.op = rotate_left_carry;
               `RC_BY_RR:    dec.op = rotate_right_carry;
               `RC_BY_CLR: begin
                  if (dst) dec.op = clear_file_reg;
                  else if (lo == `RC_LO_CLRACC) dec.op = clear_accumulator;
               end
               `RC_BY_MISC: begin
                  if (dst) dec.op = store_acc_to_file;
                  else if (lo == `RC_LO_RET) dec.op = return_sub;
                  else if (lo == `RC_LO_RETI) dec.op = interrupt_return;
                  else if (lo == `RC_LO_WDT) dec.op = watchdog_clear;
                  else if (lo == `RC_LO_STBY) dec.op = enter_standby;
               end
               default: ;
            endcase
         end
         `RC_CLS_BIT: begin
            case (instr[11:10])
               `RC_BF_CLR: dec.op = bit_clear;
               `RC_BF_SET: dec.op = bit_set;
               `RC_BF_TSC: dec.op = bit_test_skip_clear;
               default:    dec.op = bit_test_skip_set;
            endcase
         end
         `RC_CLS_CTL: dec.op = instr[11] ? jump_absolute : call_sub;
         default: begin
            casez (instr[11:8])
               4'b111?: dec.op = add_literal;
               4'b110?: dec.op = sub_acc_from_literal;
               4'b1000: dec.op = or_literal;
               4'b1001: dec.op = and_literal;
               4'b1010: dec.op = xor_literal;
               4'b00??: dec.op = load_literal;
               4'b01??: dec.op = return_with_literal;
               default: ;
            endcase
         end
      endcase
      case (dec.op)
         add_acc_to_file, sub_acc_from_file: dec.flg = `RC_FLG_ALL;
         and_acc_with_file, xor_acc_with_file, complement_file_reg, move_file_reg,
         increment_file_reg, decrement_file_reg, clear_file_reg, clear_accumulator:
            dec.flg = `RC_FLG_Z;
         rotate_left_carry, rotate_right_carry: dec.flg = `RC_FLG_C;
         bit_clear, bit_set: dec.to_file = 1'b1;
         add_literal, sub_acc_from_literal: begin
            dec.flg = `RC_FLG_ALL;
            dec.use_lit = 1'b1;
            dec.to_acc = 1'b1;
         end
         or_literal, and_literal, xor_literal: begin
            dec.flg = `RC_FLG_Z;
            dec.use_lit = 1'b1;
            dec.to_acc = 1'b1;
         end
         load_literal: begin
            dec.use_lit = 1'b1;
            dec.to_acc = 1'b1;
         end
         return_with_literal: begin
            dec.use_lit = 1'b1;
            dec.to_acc = 1'b1;
            dec.two_cyc = 1'b1;
         end
         call_sub, jump_absolute, return_sub, interrupt_return: dec.two_cyc = 1'b1;
         default: ;
      endcase
      if (dec.op inside {no_operation, return_sub, interrupt_return, watchdog_clear,
                         enter_standby}) begin
         dec.to_file = 1'b0;
         dec.to_acc = 1'b0;
      end
   end
endmodule : rc_decode

// file: rc_map.svh
// Constants for the 14-bit instruction decoder core.
// Function
// - Byte ops: class 00, four-bit code, destination bit, seven-bit file address.
// - Code 0111 adds W to file, 0010 subtracts W; both update carry, digit carry, zero.
// - Codes 0101, 0100, 0110 are AND, OR, XOR with file; AND and XOR set Z.
// - Code 1001 complements, 1000 moves, both set Z; 1110 swaps nibbles, no flags.
// - Code 1010 increments, 0011 decrements file; both set Z, write destination.
// - Codes 1011, 1111 decrement or increment, no flags, skip next on zero.
// - Codes 1101, 1100 rotate left or right through carry, updating only carry.
// - Code 0001 clears file when bit 7 set, W when low byte is 03; Z set.
// - Code 0000 with bit 7 stores W to file; low byte 0000 0xx0 does nothing.
// - Bit ops: class 01, function, bit index, file address; 00 clears, 01 sets.
// - Bit functions 10, 11 skip next when bit clear or set; two cycles when the skip is taken.
// - Class 10 is call (bit 11 clear) or jump, eleven-bit target, two cycles.
// - Class 11 codes 111x, 110x add W to literal or subtract; carry, digit carry, zero.
// - Class 11 patterns 1000, 1001, 1010 are OR, AND, XOR literal; set Z.
// - Pattern 00xx loads literal in one cycle; 01xx loads and returns, two cycles.
// - Low byte 08 returns from subroutine, 09 from interrupt; two cycles each.
// - Low byte 64 clears watchdog, 63 enters standby; both update timeout, powerdown.
// - A port register read for rewrite takes the pin levels, not the latch.
// - A write to the first timer count clears its prescaler when assigned there.
// - Branches and true conditional tests take two cycles, second one a no-operation.
// - Destination bit 0 writes result to W, 1 writes it back to the file.
// - Literal operand is the low eight bits, unsigned zero through 255.
// - An instruction cycle is four clocks; two-cycle instructions take eight.
`ifndef RC_MAP_SVH
`define RC_MAP_SVH
`define RC_IW          14
`define RC_FADDR_HI    6
`define RC_DEST_BIT    7
`define RC_BIT_HI      9
`define RC_BIT_LO      7
`define RC_LIT_HI      7
`define RC_TGT_HI      10
`define RC_CLS_BYTE    2'h0
`define RC_CLS_BIT     2'h1
`define RC_CLS_CTL     2'h2
`define RC_CLS_LIT     2'h3
`define RC_BY_MISC     4'h0
`define RC_BY_CLR      4'h1
`define RC_BY_SUB      4'h2
`define RC_BY_DEC      4'h3
`define RC_BY_IOR      4'h4
`define RC_BY_AND      4'h5
`define RC_BY_XOR      4'h6
`define RC_BY_ADD      4'h7
`define RC_BY_MOV      4'h8
`define RC_BY_COM      4'h9
`define RC_BY_INC      4'ha
`define RC_BY_DECSZ    4'hb
`define RC_BY_RR       4'hc
`define RC_BY_RL       4'hd
`define RC_BY_SWAP     4'he
`define RC_BY_INCSZ    4'hf
`define RC_LO_CLRACC   8'h03
`define RC_LO_RET      8'h08
`define RC_LO_RETI     8'h09
`define RC_LO_STBY     8'h63
`define RC_LO_WDT      8'h64
`define RC_LO_IDLEMASK 8'hf9
`define RC_BF_CLR      2'h0
`define RC_BF_SET      2'h1
`define RC_BF_TSC      2'h2
`define RC_BF_TSS      2'h3
`define RC_FLG_ALL     3'h7
`define RC_FLG_Z       3'h1
`define RC_FLG_C       3'h4
`define RC_Q_READ      2'h2
`define RC_Q_LAST      2'h3
`define RC_STAT_RST    5'h18
`define RC_W_RST       8'h00
`define RC_TMR_ADDR    7'h01
`define RC_PORT_BASE   7'h05
`define RC_PORTS       5
`endif

// file: rc_pkg.sv
// Types shared by the instruction decoder core.
package rc_pkg;
   typedef enum logic [5:0] {
      no_operation, add_acc_to_file, sub_acc_from_file, and_acc_with_file,
      or_acc_with_file, xor_acc_with_file, complement_file_reg, move_file_reg,
      swap_nibbles, increment_file_reg, decrement_file_reg, decrement_skip_zero,
      increment_skip_zero, rotate_left_carry, rotate_right_carry, clear_file_reg,
      clear_accumulator, store_acc_to_file, bit_clear, bit_set,
      bit_test_skip_clear, bit_test_skip_set, call_sub, jump_absolute,
      add_literal, sub_acc_from_literal, or_literal, and_literal, xor_literal,
      load_literal, return_with_literal, return_sub, interrupt_return,
      watchdog_clear, enter_standby
   } rc_op_t;
   typedef enum logic [2:0] {pgm_step, pgm_call, pgm_jump, pgm_ret, pgm_reti} rc_pgm_op_t;
   typedef struct packed {
      rc_op_t      op;
      logic        to_file;
      logic        to_acc;
      logic [2:0]  flg;
      logic        use_lit;
      logic        two_cyc;
      logic [6:0]  faddr;
      logic [2:0]  bitn;
      logic [7:0]  lit;
      logic [10:0] target;
   } rc_dec_t;
   typedef struct packed {
      logic [6:0] addr;
      logic       we;
      logic [7:0] wdata;
   } rc_file_t;
   typedef struct packed {
      logic        valid;
      rc_pgm_op_t  op;
      logic [10:0] target;
   } rc_pgm_t;
   typedef struct packed {
      logic timeout_flag;
      logic powerdown_flag;
      logic z;
      logic digit_carry_flag;
      logic c;
   } rc_status_t;
   typedef struct packed {
      logic [7:0] res;
      logic       c;
      logic       dcarry;
   } rc_alu_t;
endpackage : rc_pkg

// file: rc_prog_mem.sv
// Program memory and file RAM that sit beside the core.
`timescale 1ns/1ps
module rc_prog_mem (
   input  wire logic        mclk,
   input  wire logic        cyc_start,
   input  rc_pkg::rc_file_t file_bus,
   output logic [13:0]      instr,
   output logic [7:0]       file_rd_data
);
   import rc_pkg::*;
   logic [13:0] prog [512];
   logic [7:0]  ram [128];
   int          program_counter = 0;
   // The next word is offered one clock after the core has taken the last one.
   assign instr = prog[program_counter];
   assign file_rd_data = ram[file_bus.addr];
   always @(posedge mclk) begin
      if (cyc_start)
         program_counter <= program_counter + 1;
      if (file_bus.we)
         ram[file_bus.addr] <= file_bus.wdata;
   end
endmodule : rc_prog_mem
